//--- hdl/pnl_node.sv
// Panel node link and status logic: network selection with backoff,
// connect indicators, and the switch-to-indicator functional test.
// Assumes the network transceiver reports link-up per network, and that
// the host side consumes one switch event per acknowledge.
//
// Overview of operation
// - Try network B four seconds before waiting
// - Wait four seconds first, then add twelve
// - Wait growth stops at seventeen minutes
// - Test fault flash lit one eighth period
// - Only reset button or host command ends test
// - Report switch presses and faults during test
// - In test, closed switch lights matching indicator
// - 128 switch inputs, 128 indicator outputs
// - Exactly one of five connection states
// - Connect lit when connected, B only on B
// - Fall back to B only when A fails
`timescale 1ns/1ns
`include "pnl_params.svh"
module pnl_node
#(
   parameter int CYC_PER_SEC = `PNL_CLK_HZ   // Shorten for simulation
)
(
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         link_up_a,
   input  wire logic         link_up_b,
   output logic              net_sel_b,
   output logic              net_enable,
   output logic              connected_a,
   output logic              connected_b,
   output logic              connect_led,
   output logic              net_b_led,
   input  wire logic [127:0] switch_in,
   input  wire logic [127:0] switch_fault,
   output logic      [127:0] indicator_out,
   input  wire logic [127:0] indicator_cmd,
   input  wire logic         reset_button,
   input  wire logic         host_test_start,
   input  wire logic         host_reset_cmd,
   output logic              test_active,
   output logic              fault_led,
   output logic              event_valid,
   input  wire logic         event_ready,
   output logic [6:0]        event_chan,
   output logic              event_closed,
   output logic              event_fault
);

   localparam int NCH = `PNL_CHANNELS;

   // Synchronised pin inputs
   logic [NCH-1:0] sw_s;          // Switch contacts
   logic [NCH-1:0] flt_s;         // Per-switch fault detect
   logic           btn_s;         // Local reset button
   logic           btn_d;         // Button delayed for edge detect
   logic [1:0]     link_s;        // Link-up from each network

   // Timing
   logic           sec_tick;      // One pulse per second
   logic [2:0]     phase;         // Eighth-second phase

   // Connection manager
   pnl_pkg::pnl_conn_t state;     // Current connection state
   logic [10:0]    sec_cnt;       // Seconds spent in current state
   logic [10:0]    wait_len;      // Length of the next disconnected wait

   // Event scanning
   logic [NCH-1:0] sw_seen;       // Switch level last reported
   logic [NCH-1:0] flt_seen;      // Fault level last reported
   logic [6:0]     scan;          // Channel being scanned

   pnl_sync #(.W(NCH)) u_sync_sw
   (
      .clk  (clk),
      .din  (switch_in),
      .dout (sw_s)
   );

   pnl_sync #(.W(NCH)) u_sync_flt
   (
      .clk  (clk),
      .din  (switch_fault),
      .dout (flt_s)
   );

   pnl_sync #(.W(3)) u_sync_misc
   (
      .clk  (clk),
      .din  ({reset_button, link_up_b, link_up_a}),
      .dout ({btn_s, link_s})
   );

   pnl_tick #(.CYC_PER_SEC(CYC_PER_SEC)) u_tick
   (
      .clk      (clk),
      .srst     (srst),
      .sec_tick (sec_tick),
      .phase    (phase)
   );

   // Connection state machine; one state at a time by construction
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state    <= pnl_pkg::PNL_TRY_A;
         sec_cnt  <= 11'h0;
         wait_len <= 11'(`PNL_WAIT_FIRST_SEC);
      end
      else
      begin
         case (state)
            pnl_pkg::PNL_TRY_A:
            begin
               // Network A is tried first after reset, link loss or wait
               if (link_s[0])
               begin
                  state    <= pnl_pkg::PNL_CONN_A;
                  sec_cnt  <= 11'h0;
                  wait_len <= 11'(`PNL_WAIT_FIRST_SEC);
               end
               else if (sec_tick && sec_cnt == 11'(`PNL_TRY_SEC - 1))
               begin
                  // A failed its attempt; only now fall back to B
                  state   <= pnl_pkg::PNL_TRY_B;
                  sec_cnt <= 11'h0;
               end
               else if (sec_tick)
                  sec_cnt <= sec_cnt + 11'h1;
            end
            pnl_pkg::PNL_TRY_B:
            begin
               if (link_s[1])
               begin
                  state    <= pnl_pkg::PNL_CONN_B;
                  sec_cnt  <= 11'h0;
                  wait_len <= 11'(`PNL_WAIT_FIRST_SEC);
               end
               else if (sec_tick && sec_cnt == 11'(`PNL_TRY_SEC - 1))
               begin
                  // Four seconds on B done, go quiet
                  state   <= pnl_pkg::PNL_WAIT;
                  sec_cnt <= 11'h0;
               end
               else if (sec_tick)
                  sec_cnt <= sec_cnt + 11'h1;
            end
            pnl_pkg::PNL_CONN_A:
            begin
               // Losing A restarts the cycle from A
               if (!link_s[0])
               begin
                  state   <= pnl_pkg::PNL_TRY_A;
                  sec_cnt <= 11'h0;
               end
            end
            pnl_pkg::PNL_CONN_B:
            begin
               // Losing B restarts from A, which may have recovered
               if (!link_s[1])
               begin
                  state   <= pnl_pkg::PNL_TRY_A;
                  sec_cnt <= 11'h0;
               end
            end
            pnl_pkg::PNL_WAIT:
            begin
               if (sec_tick && sec_cnt == wait_len - 11'h1)
               begin
                  state   <= pnl_pkg::PNL_TRY_A;
                  sec_cnt <= 11'h0;
                  // Grow the wait by twelve seconds, clamp at ceiling
                  if (wait_len + 11'(`PNL_WAIT_STEP_SEC) >= 11'(`PNL_WAIT_MAX_SEC))
                     wait_len <= 11'(`PNL_WAIT_MAX_SEC);
                  else
                     wait_len <= wait_len + 11'(`PNL_WAIT_STEP_SEC);
               end
               else if (sec_tick)
                  sec_cnt <= sec_cnt + 11'h1;
            end
            default:
            begin
               state   <= pnl_pkg::PNL_TRY_A;
               sec_cnt <= 11'h0;
            end
         endcase
      end
   end

   // Transceiver steering and connection indicators, registered
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         net_sel_b   <= 1'b0;
         net_enable  <= 1'b0;
         connected_a <= 1'b0;
         connected_b <= 1'b0;
         connect_led <= 1'b0;
         net_b_led   <= 1'b0;
      end
      else
      begin
         net_sel_b   <= (state == pnl_pkg::PNL_TRY_B) || (state == pnl_pkg::PNL_CONN_B);
         net_enable  <= (state != pnl_pkg::PNL_WAIT);
         connected_a <= (state == pnl_pkg::PNL_CONN_A);
         connected_b <= (state == pnl_pkg::PNL_CONN_B);
         connect_led <= (state == pnl_pkg::PNL_CONN_A) || (state == pnl_pkg::PNL_CONN_B);
         // B lamp means A failed its last attempt
         net_b_led   <= (state == pnl_pkg::PNL_CONN_B);
      end
   end

   // Test mode: entered by host, left only by button or host reset
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         test_active <= 1'b0;
         btn_d       <= 1'b0;
      end
      else
      begin
         btn_d <= btn_s;
         if ((btn_s && !btn_d) || host_reset_cmd)
            test_active <= 1'b0;
         else if (host_test_start)
            test_active <= 1'b1;
      end
   end

   // Fault lamp: one phase of eight lit while testing
   always_ff @(posedge clk)
   begin
      if (srst)
         fault_led <= 1'b0;
      else
         fault_led <= test_active && (phase < 3'(`PNL_FLASH_LIT));
   end

   // Per-channel indicator drive: loopback in test, host command otherwise
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_ind
         always_ff @(posedge clk)
         begin
            if (srst)
               indicator_out[gi] <= 1'b0;
            else if (test_active)
               indicator_out[gi] <= sw_s[gi];
            else
               indicator_out[gi] <= indicator_cmd[gi];
         end
      end
   endgenerate

   // Event scanner: walks channels, reports a change to the host
   // One event at a time; a change held until its channel comes round.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         scan         <= 7'h0;
         sw_seen      <= '0;
         flt_seen     <= '0;
         event_valid  <= 1'b0;
         event_chan   <= 7'h0;
         event_closed <= 1'b0;
         event_fault  <= 1'b0;
      end
      else if (event_valid)
      begin
         // Hold the event until the host takes it
         if (event_ready)
            event_valid <= 1'b0;
      end
      else
      begin
         scan <= scan + 7'h1;
         if (test_active &&
             (sw_s[scan] != sw_seen[scan] || flt_s[scan] != flt_seen[scan]))
         begin
            event_valid    <= 1'b1;
            event_chan     <= scan;
            event_closed   <= sw_s[scan];
            event_fault    <= flt_s[scan];
            sw_seen[scan]  <= sw_s[scan];
            flt_seen[scan] <= flt_s[scan];
         end
         else if (!test_active)
         begin
            // Track levels so test entry reports only fresh changes
            sw_seen[scan]  <= sw_s[scan];
            flt_seen[scan] <= flt_s[scan];
         end
      end
   end

endmodule

//--- hdl/pnl_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
// Assumes inputs come from outside the clock domain.
`timescale 1ns/1ns
module pnl_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta; // First stage, read only by second stage

   // Plain double flop; no reset so pin levels settle freely
   always_ff @(posedge clk)
   begin
      meta <= din;
      dout <= meta;
   end

endmodule

//--- hdl/pnl_tick.sv
// Divider producing a one-cycle pulse once per second and a three-bit
// phase that steps eight times per second for indicator flashing.
// Assumes a 100 MHz clock and synchronous active-high reset.
`timescale 1ns/1ns
`include "pnl_params.svh"
module pnl_tick
#(
   parameter int CYC_PER_SEC = `PNL_CLK_HZ
)
(
   input  wire logic       clk,
   input  wire logic       srst,
   output logic            sec_tick,
   output logic [2:0]      phase
);

   localparam int PH_CYC = CYC_PER_SEC / `PNL_FLASH_PHASES;

   logic [31:0] cnt; // Cycle count within one eighth second

   // Eighth-second divider; phase wraps once per second
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt      <= 32'h0;
         phase    <= 3'h0;
         sec_tick <= 1'b0;
      end
      else if (cnt == 32'(PH_CYC - 1))
      begin
         cnt      <= 32'h0;
         phase    <= phase + 3'h1;
         sec_tick <= (phase == 3'h7);
      end
      else
      begin
         cnt      <= cnt + 32'h1;
         sec_tick <= 1'b0;
      end
   end

endmodule

//--- pkg/pnl_params.svh
// Constants for the panel node link and status block: timing counts and
// indicator patterns. Assumes a 100 MHz system clock.
`ifndef PNL_PARAMS_SVH
`define PNL_PARAMS_SVH

`define PNL_CLK_HZ          100000000
// Connection attempt time per network, seconds
`define PNL_TRY_SEC         4
// First disconnected wait, seconds
`define PNL_WAIT_FIRST_SEC  4
// Growth of the wait per failed cycle, seconds
`define PNL_WAIT_STEP_SEC   12
// Ceiling of the wait, minutes
`define PNL_WAIT_MAX_MIN    17
// Ceiling in seconds
`define PNL_WAIT_MAX_SEC    (`PNL_WAIT_MAX_MIN * 60)
// Flash period in ticks of the second tick divider, eight phases
`define PNL_FLASH_PHASES    8
`define PNL_FLASH_LIT       1
// Number of switch inputs and indicator outputs
`define PNL_CHANNELS        128

`endif

//--- pkg/pnl_pkg.sv
// Types for the panel node link and status block.
// Assumes pnl_params.svh is included by the design files.
package pnl_pkg;

   // Connection manager states
   typedef enum logic [2:0]
   {
      PNL_TRY_A   = 3'h0,
      PNL_TRY_B   = 3'h1,
      PNL_CONN_A  = 3'h2,
      PNL_CONN_B  = 3'h3,
      PNL_WAIT    = 3'h4
   } pnl_conn_t;

endpackage

//--- tb/pnl_host_model.sv
// Host model: takes switch events and keeps a switch and fault map.
// Assumes the node holds each event until ready is seen high.
`timescale 1ns/1ns
module pnl_host_model
(
   input  wire logic       clk,
   input  wire logic       clr,
   input  wire logic       slow,
   input  wire logic       event_valid,
   input  wire logic [6:0] event_chan,
   input  wire logic       event_closed,
   input  wire logic       event_fault,
   output logic            event_ready = 0,
   output logic [127:0]    closed_map = '0,
   output logic [127:0]    fault_map = '0,
   output int              n_events = 0
);
   logic [1:0] pace = 0;  // Slow mode accepts one cycle in four

   // Acceptance and map keeping, changed only just after an edge
   always @(posedge clk)
   begin
      pace <= pace + 2'h1;
      event_ready <= !slow || (pace == 2'h3);
      if (clr)
      begin
         closed_map <= '0;
         fault_map <= '0;
         n_events <= 0;
      end
      else if (event_valid && event_ready)
      begin
         closed_map[event_chan] <= event_closed;
         fault_map[event_chan] <= event_fault;
         n_events <= n_events + 1;
      end
   end
endmodule

//--- tb/pnl_node_props.sv
// Checker for the panel node: connection indicators, test and events.
// Assumes one clock domain and a synchronous active-high srst.
`timescale 1ns/1ns
`include "pnl_params.svh"
module pnl_node_props
#(
   parameter int CYC_PER_SEC = `PNL_CLK_HZ
)
(
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       net_sel_b,
   input wire logic       net_enable,
   input wire logic       connected_a,
   input wire logic       connected_b,
   input wire logic       connect_led,
   input wire logic       net_b_led,
   input wire logic       reset_button,
   input wire logic       host_test_start,
   input wire logic       host_reset_cmd,
   input wire logic       test_active,
   input wire logic       fault_led,
   input wire logic       event_valid,
   input wire logic       event_ready,
   input wire logic [6:0] event_chan,
   input wire logic       event_closed,
   input wire logic       event_fault
);
   int lit_run;  // Length of the current lit run of the fault flash

   // Counts lit cycles, so a flash stuck on is caught after one eighth second
   always_ff @(posedge clk)
   begin
      if (srst || !fault_led)
         lit_run <= 0;
      else
         lit_run <= lit_run + 1;
   end

   longint off_run;  // Length of the current disconnected wait, in cycles

   // Counts cycles with the transceiver off; wide so a full-rate ceiling fits
   always_ff @(posedge clk)
   begin
      if (srst || net_enable)
         off_run <= 0;
      else
         off_run <= off_run + 1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Button low long enough that no synced edge can be pending
   sequence s_quiet;
      !reset_button [*5];
   endsequence
   // Event offered but not yet taken
   sequence s_held;
      event_valid && !event_ready;
   endsequence

   a_conn_led: assert property (connect_led == (connected_a || connected_b))
      else $error("connect led does not match connection");
   a_netb_led: assert property (net_b_led == connected_b)
      else $error("network b led does not match connection");
   a_one_state: assert property (!(connected_a && connected_b))
      else $error("connected on both networks");
   a_netb_path: assert property (net_b_led |-> net_sel_b && net_enable)
      else $error("network b led lit while not on network b");
   a_event_hold: assert property (s_held |=> event_valid && $stable(event_chan)
      && $stable(event_closed) && $stable(event_fault))
      else $error("event changed before it was taken");
   a_event_drop: assert property (event_valid && event_ready |=> !event_valid)
      else $error("event not retired after acceptance");
   a_test_enter: assert property (s_quiet ##0 (host_test_start && !host_reset_cmd)
      |=> test_active)
      else $error("test not entered");
   a_test_holds: assert property (s_quiet ##0 (test_active && !host_reset_cmd)
      |=> test_active)
      else $error("test ended without a reset");
   a_host_end: assert property (host_reset_cmd |=> !test_active)
      else $error("host reset did not end the test");
   a_flash_off: assert property (!test_active [*2] |-> !fault_led)
      else $error("fault flash lit outside test");
   a_flash_lit: assert property (lit_run <= CYC_PER_SEC / 8)
      else $error("fault flash lit too long");
   a_wait_cap: assert property (off_run <= longint'(`PNL_WAIT_MAX_SEC) * CYC_PER_SEC)
      else $error("disconnected wait above its ceiling");
endmodule

bind pnl_node pnl_node_props #(.CYC_PER_SEC(CYC_PER_SEC)) u_props
(
   .clk, .srst, .net_sel_b, .net_enable, .connected_a, .connected_b, .connect_led,
   .net_b_led, .reset_button, .host_test_start, .host_reset_cmd, .test_active,
   .fault_led, .event_valid, .event_ready, .event_chan, .event_closed, .event_fault
);

//--- tb/pnl_node_tb.sv
// Bench for the panel node: backoff, fall back, functional test.
// Assumes a shortened second of 80 cycles.
`timescale 1ns/1ns
module pnl_node_tb;
   localparam int T = 80;  // Cycles per second in simulation
   logic clk = 0, srst = 1, link_up_a = 0, link_up_b = 0;
   logic reset_button = 0, host_test_start = 0, host_reset_cmd = 0;
   logic clr = 0, slow = 1;
   logic [127:0] switch_in = '0, switch_fault = '0, indicator_cmd = 128'hA5;
   logic net_sel_b, net_enable, connected_a, connected_b, connect_led, net_b_led;
   logic test_active, fault_led, event_valid, event_ready, event_closed, event_fault;
   logic [6:0] event_chan;
   logic [127:0] indicator_out, closed_map, fault_map;
   int n_events;
   int n_mismatch = 0;
   int comparisons = 0;

   always #5 clk = ~clk;

   pnl_node #(.CYC_PER_SEC(T)) DUT (.clk, .srst, .link_up_a, .link_up_b, .net_sel_b,
      .net_enable, .connected_a, .connected_b, .connect_led, .net_b_led, .switch_in,
      .switch_fault, .indicator_out, .indicator_cmd, .reset_button, .host_test_start,
      .host_reset_cmd, .test_active, .fault_led, .event_valid, .event_ready,
      .event_chan, .event_closed, .event_fault);
   pnl_host_model host (.clk, .clr, .slow, .event_valid, .event_chan, .event_closed,
      .event_fault, .event_ready, .closed_map, .fault_map, .n_events);

   task automatic results();
      if (n_mismatch == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic check(input string w, input logic [127:0] e, input logic [127:0] s);
      comparisons++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic in_range(input string w, input int lo, input int hi, input int s);
      comparisons++;
      if (s < lo || s > hi)
      begin
         n_mismatch++;
         $display("wrong value %s expected %0d..%0d seen %0d", w, lo, hi, s);
      end
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return connected_a;
         1: return connected_b;
         2: return net_enable;
         default: return test_active;
      endcase
   endfunction
   // Bounded wait for a level; running out ends the run as a failure
   task automatic wait_lvl(input int w, input logic v, output int n);
      n = 0;
      #1;
      while (sig(w) !== v)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n > 3000)
         begin
            n_mismatch++;
            results();
         end
      end
   endtask

   // Both links dead: try windows and growing waits, then reset of backoff
   task automatic t_backoff();
      int n;
      wait_lvl(2, 1, n);
      wait_lvl(2, 0, n);
      in_range("first try", 6 * T, 8 * T + 8, n);
      wait_lvl(2, 1, n);
      in_range("first wait", 3 * T, 4 * T + 8, n);
      wait_lvl(2, 0, n);
      wait_lvl(2, 1, n);
      in_range("second wait", 15 * T, 16 * T + 8, n);
      @(posedge clk) link_up_a <= 1;
      wait_lvl(0, 1, n);
      check("connect_led", 1, connect_led);
      check("net_b_led", 0, net_b_led);
      @(posedge clk) link_up_a <= 0;
      wait_lvl(2, 0, n);
      wait_lvl(2, 1, n);
      in_range("wait after link", 3 * T, 4 * T + 8, n);
   endtask

   // Network A lost with B alive: B is used only after A's window
   task automatic t_fallback();
      int n;
      @(posedge clk) link_up_a <= 1;
      wait_lvl(0, 1, n);
      @(posedge clk)
      begin
         link_up_a <= 0;
         link_up_b <= 1;
      end
      wait_lvl(1, 1, n);
      in_range("fall back", 3 * T, 4 * T + 8, n);
      check("net_b_led", 1, net_b_led);
      check("connected_a", 0, connected_a);
      @(posedge clk) link_up_b <= 0;
      wait_lvl(1, 0, n);
      check("connect_led off", 0, connect_led);
   endtask

   // Functional test: loop, events, flash, and both ways to end it
   task automatic t_test();
      int n;
      int lit;
      logic [127:0] pat;
      pat = {1'b1, 121'h0, 6'h21};
      @(posedge clk) clr <= 1;
      @(posedge clk) clr <= 0;
      @(posedge clk) host_test_start <= 1;
      @(posedge clk) host_test_start <= 0;
      wait_lvl(3, 1, n);
      @(posedge clk)
      begin
         switch_in <= pat;
         switch_fault <= 128'h1 << 64;
      end
      n = 0;
      while (n_events < 4 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000)
      begin
         n_mismatch++;
         results();
      end
      #1;
      check("indicator_out", pat, indicator_out);
      check("closed map", pat, closed_map);
      check("fault map", 128'h1 << 64, fault_map);
      lit = 0;
      // One whole flash period, so the lit share is exactly one eighth
      repeat (T)
      begin
         @(posedge clk);
         #1;
         if (fault_led === 1'b1)
            lit++;
      end
      in_range("flash lit", T / 8, T / 8, lit);
      check("test_active", 1, test_active);
      @(posedge clk) reset_button <= 1;
      wait_lvl(3, 0, n);
      @(posedge clk) reset_button <= 0;
      @(posedge clk) switch_in <= '0;
      repeat (300) @(posedge clk);
      #1;
      check("indicator idle", indicator_cmd, indicator_out);
      check("events outside test", 4, n_events);
      @(posedge clk) host_test_start <= 1;
      @(posedge clk) host_test_start <= 0;
      wait_lvl(3, 1, n);
      @(posedge clk) host_reset_cmd <= 1;
      @(posedge clk) host_reset_cmd <= 0;
      #1;
      check("host end", 0, test_active);
   endtask

   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 0;
      t_backoff();
      t_fallback();
      t_test();
      results();
   end
endmodule
